// *** design/mdiou_regs.svh ***
`ifndef MDIOU_REGS_SVH
`define MDIOU_REGS_SVH

// ---------------------------------------------------------------
// Register byte offsets.
// ---------------------------------------------------------------
`define MDIOU_DEB_LO 8'h00
`define MDIOU_DEB_HI 8'h04
`define MDIOU_LINK 8'h08
`define MDIOU_SYNC 8'h0C
`define MDIOU_RMODE 8'h10
`define MDIOU_REMOTE 8'h14
`define MDIOU_PWIDTH 8'h18
`define MDIOU_BMUL 8'h1C
`define MDIOU_STATUS 8'h20
`define MDIOU_CNT_SEL 3'h2
`define MDIOU_BILL_SEL 3'h3

// ---------------------------------------------------------------
// Field positions.
// ---------------------------------------------------------------
`define MDIOU_LINK_BILL 0
`define MDIOU_LINK_CNT 8
`define MDIOU_LINK_FLT 16
`define MDIOU_LINK_FLTEXT 24
`define MDIOU_SYNC_DSEL 0
`define MDIOU_SYNC_DEN 3
`define MDIOU_SYNC_CSEL 4
`define MDIOU_SYNC_CEN 7
`define MDIOU_SYNC_TEN 8
`define MDIOU_SYNC_TBASE 9
`define MDIOU_SYNC_PRES 12
`define MDIOU_RM_MODE 0
`define MDIOU_RM_INV 2
`define MDIOU_RM_SRC 3
`define MDIOU_REM_REL 4

// ---------------------------------------------------------------
// Reset values.
// ---------------------------------------------------------------
`define MDIOU_DEB_RST 32'h0A0A_0A0A
`define MDIOU_PWIDTH_RST 32'h0000_0A0A
`define MDIOU_BMUL_RST 32'h0000_0001

// ---------------------------------------------------------------
// Timing.
// ---------------------------------------------------------------
`define MDIOU_CLK_PERIOD_NS 50
`define MDIOU_MS_NS 1000000
`define MDIOU_DEB_MIN 7'h01
`define MDIOU_DEB_MAX 7'h64

`endif

// *** design/mdiou_pkg.sv ***
`default_nettype none

package mdiou_pkg;

   // Relay operating modes, in register encoding order.
   typedef enum logic [1:0] {
      MDIOU_LATCHED,
      MDIOU_UNLATCHED,
      MDIOU_PULSE,
      MDIOU_TOGGLE
   } mdiou_mode_e;

   // What operates a relay.
   typedef enum logic [1:0] {
      MDIOU_SRC_SETPOINT,
      MDIOU_SRC_REMOTE,
      MDIOU_SRC_PULSE,
      MDIOU_SRC_TARIFF
   } mdiou_src_e;

endpackage

`default_nettype wire

// *** design/mdiou_debounce.sv ***
`timescale 1ns/10ps
`default_nettype none
`include "mdiou_regs.svh"

module mdiou_debounce
   import mdiou_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic sample,
   input wire logic ms_tick,
   input wire logic din,
   input wire logic [6:0] deb_ms,
   output logic dout
);

   typedef struct packed {
      logic samp;
      logic state;
      logic [6:0] cnt;
   } mdiou_deb_s;

   mdiou_deb_s r, r_nxt;
   logic [6:0] lim;

   // ------------------------------------------------------------
   // Settling filter.
   // ------------------------------------------------------------
   // Out of range settings are clamped so the filter never hangs.
   always_comb begin
      lim = deb_ms;
      if (deb_ms < `MDIOU_DEB_MIN) begin
         lim = `MDIOU_DEB_MIN;
      end else if (deb_ms > `MDIOU_DEB_MAX) begin
         lim = `MDIOU_DEB_MAX;
      end
      r_nxt = r;
      if (sample) begin
         r_nxt.samp = din;
      end
      // A sample that returns to the held level restarts the wait.
      if (r.samp == r.state) begin
         r_nxt.cnt = 7'h00;
      end else if (ms_tick) begin
         if (7'(r.cnt + 7'h01) >= lim) begin
            r_nxt.state = r.samp;
            r_nxt.cnt = 7'h00;
         end else begin
            r_nxt.cnt = 7'(r.cnt + 7'h01);
         end
      end
   end

   // State register.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         r <= '0;
      end else begin
         r <= r_nxt;
      end
   end

   assign dout = r.state;

endmodule // mdiou_debounce

`default_nettype wire

// *** design/mdiou_relay.sv ***
`timescale 1ns/10ps
`default_nettype none

module mdiou_relay
   import mdiou_pkg::*;
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic hc_tick,
   input wire logic enable,
   input wire mdiou_mode_e mode,
   input wire logic invert,
   input wire logic trig,
   input wire logic ev,
   input wire logic release_cmd,
   input wire logic [7:0] width,
   output logic coil,
   output logic active
);

   typedef struct packed {
      logic act;
      logic tpre;
      logic ev_p;
      logic rel_p;
      logic [7:0] cnt;
      logic coil;
   } mdiou_rly_s;

   mdiou_rly_s r, r_nxt;
   logic ev_now;
   logic rel_now;

   // ------------------------------------------------------------
   // Half-cycle relay update.
   // ------------------------------------------------------------
   // Events between ticks are held pending, so a pulse that lands
   // on the tick itself still counts in that update.
   always_comb begin
      r_nxt = r;
      ev_now = r.ev_p | ev;
      rel_now = r.rel_p | release_cmd;
      r_nxt.ev_p = ev_now;
      r_nxt.rel_p = rel_now;
      if (hc_tick) begin
         r_nxt.ev_p = 1'b0;
         r_nxt.rel_p = 1'b0;
         r_nxt.tpre = trig;
         case (mode)
            MDIOU_LATCHED: begin
               if (trig) begin
                  r_nxt.act = 1'b1;
               end else if (rel_now) begin
                  r_nxt.act = 1'b0;
               end
            end
            MDIOU_UNLATCHED: begin
               r_nxt.act = trig;
            end
            MDIOU_PULSE: begin
               if ((trig & ~r.tpre) | ev_now) begin
                  r_nxt.act = 1'b1;
                  r_nxt.cnt = width;
               end else if (r.cnt > 8'h01) begin
                  r_nxt.cnt = 8'(r.cnt - 8'h01);
               end else begin
                  r_nxt.cnt = 8'h00;
                  r_nxt.act = 1'b0;
               end
            end
            default: begin
               if (ev_now) begin
                  r_nxt.act = ~r.act;
               end
            end
         endcase
         if (!enable) begin
            r_nxt.act = 1'b0;
            r_nxt.cnt = 8'h00;
         end
         // Failsafe drive: the coil rests energized when inverted.
         r_nxt.coil = r_nxt.act ^ invert;
      end
   end

   // State register.
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         r <= '0;
      end else begin
         r <= r_nxt;
      end
   end

   assign coil = r.coil;
   assign active = r.act;

endmodule // mdiou_relay

`default_nettype wire

// *** design/mdiou_unit.sv ***
// Functional notes
// - Eight inputs: four fast internal plus two per plug-in module, two modules.
// - Fast inputs sampled every millisecond, module inputs every half cycle.
// - Each input has its own debounce time of 1 to 100 ms.
// - Module input lamp lights while its input terminals are shorted.
// - Module relay lamp lights while its normally open contacts are closed.
// - Up to four relays, two on each of two plug-in modules.
// - Relay outputs are recomputed and applied once per half cycle.
// - Each relay: latched, unlatched, pulse or three-wire toggle mode.
// - Inverted relay coil energized when inactive, released when operated.
// - Relay driven by setpoint, remote command or internal pulse source.
// - One input may feed several functions at the same time.
// - Billing-linked input adds its pulses times a multiplier.
// - Counter-linked input increments its counter per accepted pulse.
// - Debounced input state is offered to setpoints as triggers.
// - Fault trigger needs input link and external trigger enable both.
// - Demand sync input marks start of a new demand interval.
// - Tariff number taken from code on selected tariff inputs.
// - Tariff change makes a programmable-width pulse on tariff relays.
//
// Decided for this implementation: the register offsets and the Avalon-MM interface to the registers.
`timescale 1ns/10ps
`default_nettype none
`include "mdiou_regs.svh"

module mdiou_unit
   import mdiou_pkg::*;
#(
   parameter int MS_CYCLES = `MDIOU_MS_NS / `MDIOU_CLK_PERIOD_NS
)
(
   input wire logic clk,
   input wire logic rstn,
   input wire logic [7:0] avs_address,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [3:0] avs_byteenable,
   output logic [31:0] avs_readdata,
   output logic avs_waitrequest,
   input wire logic [3:0] fast_in,
   input wire logic [3:0] exp_in,
   input wire logic half_cycle_tick,
   input wire logic [3:0] setpoint_req,
   input wire logic [3:0] energy_pulse,
   output logic [3:0] relay_coil,
   output logic [1:0] module_input_lamp_a,
   output logic [1:0] module_input_lamp_b,
   output logic [1:0] module_relay_lamp_a,
   output logic [1:0] module_relay_lamp_b,
   output logic [7:0] input_state,
   output logic fault_trigger,
   output logic demand_sync,
   output logic clock_sync,
   output logic [2:0] tariff_num,
   output logic tariff_change
);

   // ------------------------------------------------------------
   // State.
   // ------------------------------------------------------------
   typedef struct packed {
      logic [7:0] s1;
      logic [7:0] s2;

      logic [14:0] ms_cnt;
      logic ms_tick;

      logic ack;
      logic [31:0] rdata;

      logic [31:0] deb_lo;
      logic [31:0] deb_hi;

      logic [31:0] link;
      logic [31:0] sync;
      logic [31:0] rmode;
      logic [31:0] pwidth;
      logic [31:0] bmul;

      logic [3:0] remote;
      logic [3:0] rel;

      logic [7:0] prev;
      logic [2:0] tariff;
      logic tchg;

      logic fault;
      logic dsync;
      logic csync;

      logic [7:0][15:0] cnt;
      logic [7:0][31:0] bill;
   } mdiou_unit_s;

   mdiou_unit_s r, r_nxt;
   logic [7:0] deb;
   logic [7:0] rise;
   logic [3:0] act;

   logic [1:0] present;
   logic [63:0] deb_cfg;
   logic [2:0] tcode;
   logic [2:0] tbase;
   logic [2:0] dsel;
   logic [2:0] csel;

   // Byte-lane merge for register writes.
   function automatic logic [31:0] merge(
      input logic [31:0] old,
      input logic [31:0] wd,
      input logic [3:0] be
   );
      logic [31:0] res;

      res = old;
      for (int b = 0; b < 4; b++) begin
         if (be[b]) begin
            res[8*b +: 8] = wd[8*b +: 8];
         end
      end
      return res;
   endfunction

   // Configuration fields used by several processes.
   assign present = r.sync[`MDIOU_SYNC_PRES +: 2];

   assign deb_cfg = {r.deb_hi, r.deb_lo};
   assign tbase = r.sync[`MDIOU_SYNC_TBASE +: 3];
   assign dsel = r.sync[`MDIOU_SYNC_DSEL +: 3];
   assign csel = r.sync[`MDIOU_SYNC_CSEL +: 3];

   // ------------------------------------------------------------
   // Input filters.
   // ------------------------------------------------------------
   // Inputs 0-3 are the fast internal ones on the millisecond
   // tick; 4-5 and 6-7 belong to plug-in modules 0 and 1 and are
   // only sampled on the half-cycle tick while fitted.
   for (genvar i = 0; i < 8; i++) begin : g_in
      logic samp;

      if (i < 4) begin : g_fast
         assign samp = r.ms_tick;
      end else begin : g_exp
         assign samp = half_cycle_tick & present[(i - 4) / 2];
      end
      mdiou_debounce u_deb (
         .clk(clk),
         .rstn(rstn),
         .sample(samp),
         .ms_tick(r.ms_tick),
         .din(r.s2[i]),
         .deb_ms(deb_cfg[8*i +: 7]),
         .dout(deb[i])
      );
   end

   // Activation edges, shared by every input function but the tariff code, which reads levels.
   assign rise = deb & ~r.prev;

   // ------------------------------------------------------------
   // Relay channels.
   // ------------------------------------------------------------
   for (genvar k = 0; k < 4; k++) begin : g_rly
      mdiou_src_e src;
      logic trig;
      logic ev;

      assign src = mdiou_src_e'(r.rmode[8*k + `MDIOU_RM_SRC +: 2]);

      // Level sources operate, event sources pulse or toggle.
      assign trig = (src == MDIOU_SRC_SETPOINT) ? setpoint_req[k] :
                    (src == MDIOU_SRC_REMOTE) ? r.remote[k] : 1'b0;
      assign ev = (src == MDIOU_SRC_PULSE) ? energy_pulse[k] :
                  (src == MDIOU_SRC_TARIFF) ? r.tchg : 1'b0;
      // Module absent forces the relay inactive.
      mdiou_relay u_rly (
         .clk(clk),
         .rstn(rstn),
         .hc_tick(half_cycle_tick),
         .enable(present[k / 2]),
         .mode(mdiou_mode_e'(r.rmode[8*k + `MDIOU_RM_MODE +: 2])),
         .invert(r.rmode[8*k + `MDIOU_RM_INV]),
         .trig(trig),
         .ev(ev),
         .release_cmd(r.rel[k]),
         .width((src == MDIOU_SRC_TARIFF) ? r.pwidth[15:8] : r.pwidth[7:0]),
         .coil(relay_coil[k]),
         .active(act[k])
      );
   end

   // ------------------------------------------------------------
   // Next-state logic.
   // ------------------------------------------------------------
   always_comb begin
      r_nxt = r;

      // Pins pass two flops before anything looks at them.
      r_nxt.s1 = {exp_in, fast_in};
      r_nxt.s2 = r.s1;

      // Millisecond tick divider.
      r_nxt.ms_tick = 1'b0;

      if (r.ms_cnt == 15'(MS_CYCLES - 1)) begin
         r_nxt.ms_cnt = 15'h0000;
         r_nxt.ms_tick = 1'b1;
      end else begin
         r_nxt.ms_cnt = 15'(r.ms_cnt + 15'h0001);
      end

      // Bus answer: one wait cycle, then the request completes.
      r_nxt.ack = (avs_read | avs_write) & ~r.ack;
      r_nxt.rel = 4'h0;
      if (avs_read & ~r.ack) begin
         r_nxt.rdata = 32'h0000_0000;

         if (avs_address == `MDIOU_DEB_LO) begin
            r_nxt.rdata = r.deb_lo;
         end else if (avs_address == `MDIOU_DEB_HI) begin
            r_nxt.rdata = r.deb_hi;
         end else if (avs_address == `MDIOU_LINK) begin
            r_nxt.rdata = r.link;
         end else if (avs_address == `MDIOU_SYNC) begin
            r_nxt.rdata = r.sync;
         end else if (avs_address == `MDIOU_RMODE) begin
            r_nxt.rdata = r.rmode;
         end else if (avs_address == `MDIOU_REMOTE) begin
            r_nxt.rdata = {28'h000_0000, r.remote};
         end else if (avs_address == `MDIOU_PWIDTH) begin
            r_nxt.rdata = r.pwidth;
         end else if (avs_address == `MDIOU_BMUL) begin
            r_nxt.rdata = r.bmul;
         end else if (avs_address == `MDIOU_STATUS) begin
            r_nxt.rdata = {9'h000, r.tariff, act, r.s2, deb};
         end else if (avs_address[7:5] == `MDIOU_CNT_SEL) begin
            r_nxt.rdata = {16'h0000, r.cnt[avs_address[4:2]]};
         end else if (avs_address[7:5] == `MDIOU_BILL_SEL) begin
            r_nxt.rdata = r.bill[avs_address[4:2]];
         end
      end

      // Writes land on the cycle waitrequest is low.
      if (avs_write & r.ack) begin
         if (avs_address == `MDIOU_DEB_LO) begin
            r_nxt.deb_lo = merge(r.deb_lo, avs_writedata, avs_byteenable);
         end else if (avs_address == `MDIOU_DEB_HI) begin
            r_nxt.deb_hi = merge(r.deb_hi, avs_writedata, avs_byteenable);
         end else if (avs_address == `MDIOU_LINK) begin
            r_nxt.link = merge(r.link, avs_writedata, avs_byteenable);
         end else if (avs_address == `MDIOU_SYNC) begin
            r_nxt.sync = merge(r.sync, avs_writedata, avs_byteenable);
         end else if (avs_address == `MDIOU_RMODE) begin
            r_nxt.rmode = merge(r.rmode, avs_writedata, avs_byteenable);
         end else if (avs_address == `MDIOU_REMOTE) begin
            if (avs_byteenable[0]) begin
               r_nxt.remote = avs_writedata[3:0];
               r_nxt.rel = avs_writedata[`MDIOU_REM_REL +: 4];
            end
         end else if (avs_address == `MDIOU_PWIDTH) begin
            r_nxt.pwidth = merge(r.pwidth, avs_writedata, avs_byteenable);
         end else if (avs_address == `MDIOU_BMUL) begin
            r_nxt.bmul = merge(r.bmul, avs_writedata, avs_byteenable);
         end
      end

      // Billing, counter, fault and sync functions see the same edge independently.
      r_nxt.prev = deb;

      for (int i = 0; i < 8; i++) begin
         if (rise[i] & r.link[`MDIOU_LINK_BILL + i]) begin
            r_nxt.bill[i] = r.bill[i] + {16'h0000, r.bmul[15:0]};
         end
         if (rise[i] & r.link[`MDIOU_LINK_CNT + i]) begin
            r_nxt.cnt[i] = 16'(r.cnt[i] + 16'h0001);
         end
      end

      // Fault recorder needs both the link and the global enable.
      r_nxt.fault = r.link[`MDIOU_LINK_FLTEXT] &
                    |(rise & r.link[`MDIOU_LINK_FLT +: 8]);

      r_nxt.dsync = r.sync[`MDIOU_SYNC_DEN] & rise[dsel];

      // One pulse per minute is trusted to come from the master.
      r_nxt.csync = r.sync[`MDIOU_SYNC_CEN] & rise[csel];

      // Tariff code from three inputs starting at the base input.
      for (int t = 0; t < 3; t++) begin
         tcode[t] = deb[3'(tbase + 3'(t))];
      end

      r_nxt.tchg = 1'b0;
      if (r.sync[`MDIOU_SYNC_TEN] && tcode != r.tariff) begin
         r_nxt.tariff = tcode;
         r_nxt.tchg = 1'b1;
      end
   end

   // ------------------------------------------------------------
   // State register.
   // ------------------------------------------------------------
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         r <= '0;
         r.deb_lo <= `MDIOU_DEB_RST;
         r.deb_hi <= `MDIOU_DEB_RST;
         r.pwidth <= `MDIOU_PWIDTH_RST;
         r.bmul <= `MDIOU_BMUL_RST;
      end else begin
         r <= r_nxt;
      end
   end

   // ------------------------------------------------------------
   // Outputs.
   // ------------------------------------------------------------
   assign avs_waitrequest = (avs_read | avs_write) & ~r.ack;
   assign avs_readdata = r.rdata;

   // Input lamps follow the terminals, unfiltered, like a real LED.
   assign module_input_lamp_a = {r.s2[6], r.s2[4]} & present;
   assign module_input_lamp_b = {r.s2[7], r.s2[5]} & present;

   // The normally open contacts close while the coil is energized.
   assign module_relay_lamp_a = {relay_coil[2], relay_coil[0]};
   assign module_relay_lamp_b = {relay_coil[3], relay_coil[1]};

   // Filtered state and one-cycle event pulses.
   assign input_state = deb;
   assign fault_trigger = r.fault;
   assign demand_sync = r.dsync;
   assign clock_sync = r.csync;
   assign tariff_num = r.tariff;
   assign tariff_change = r.tchg;

endmodule // mdiou_unit

`default_nettype wire

// *** bench/mdiou_contacts.sv ***
`timescale 1ns/10ps
`default_nettype none

module mdiou_contacts (
   input wire logic clk,
   input wire logic [7:0] shorted,
   output logic [3:0] fast_in = 4'h0,
   output logic [3:0] exp_in = 4'h0
);
   // ----
   // Contacts
   // ----
   // A shorted pair reads high; pins move just after an edge, as real
   // contacts never line up with our clock anyway.
   always @(posedge clk) begin
      fast_in <= shorted[3:0];
      exp_in <= shorted[7:4];
   end
endmodule // mdiou_contacts

`default_nettype wire

// *** bench/mdiou_unit_props.sv ***
`timescale 1ns/10ps
`default_nettype none

module mdiou_unit_props (
   input wire logic clk,
   input wire logic rstn,
   input wire logic avs_read,
   input wire logic avs_write,
   input wire logic avs_waitrequest,
   input wire logic [3:0] exp_in,
   input wire logic half_cycle_tick,
   input wire logic [3:0] relay_coil,
   input wire logic [1:0] module_input_lamp_a,
   input wire logic [1:0] module_relay_lamp_a,
   input wire logic [1:0] module_relay_lamp_b,
   input wire logic [7:0] input_state,
   input wire logic fault_trigger,
   input wire logic demand_sync,
   input wire logic clock_sync
);
   // ----
   // Checks
   // ----
   // One clock domain, so every check shares the clock and the reset.
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);
   sequence s_req_start;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence
   sequence s_answer;
      !avs_waitrequest;
   endsequence
   a_wait_one: assert property (s_req_start |=> s_answer)
      else $error("bus answer late");
   a_wait_idle: assert property (!(avs_read || avs_write) |-> s_answer)
      else $error("wait raised while idle");
   a_relay_tick: assert property ($changed(relay_coil) |-> $past(half_cycle_tick))
      else $error("relay moved off the half-cycle tick");
   a_relay_lamp: assert property (module_relay_lamp_a == {relay_coil[2], relay_coil[0]}
      && module_relay_lamp_b == {relay_coil[3], relay_coil[1]})
      else $error("relay lamp differs from contact");
   a_input_lamp: assert property (module_input_lamp_a[0] |-> $past(exp_in[0], 2))
      else $error("input lamp lit with terminals open");
   a_demand_edge: assert property (demand_sync |->
      |($past(input_state) & ~$past(input_state, 2)))
      else $error("demand sync without input rise");
   a_fault_edge: assert property (fault_trigger |->
      |($past(input_state) & ~$past(input_state, 2)))
      else $error("fault trigger without input rise");
   a_clock_edge: assert property (clock_sync |->
      |($past(input_state) & ~$past(input_state, 2)))
      else $error("clock sync without input rise");
endmodule // mdiou_unit_props

bind mdiou_unit mdiou_unit_props mdiou_unit_props_inst (.clk(clk), .rstn(rstn),
   .avs_read(avs_read), .avs_write(avs_write), .avs_waitrequest(avs_waitrequest),
   .exp_in(exp_in), .half_cycle_tick(half_cycle_tick), .relay_coil(relay_coil),
   .module_input_lamp_a(module_input_lamp_a), .module_relay_lamp_a(module_relay_lamp_a),
   .module_relay_lamp_b(module_relay_lamp_b), .input_state(input_state),
   .fault_trigger(fault_trigger), .demand_sync(demand_sync), .clock_sync(clock_sync));

`default_nettype wire

// *** bench/meter_digital_io_unit_test.sv ***
`timescale 1ns/10ps
`default_nettype none

module meter_digital_io_unit_test;
   logic clk = 1'b0;
   logic rstn = 1'b0;
   logic [7:0] avs_address = 8'h00;
   logic avs_read = 1'b0;
   logic avs_write = 1'b0;
   logic [31:0] avs_writedata = 32'h0000_0000;
   logic [31:0] avs_readdata, q;
   logic avs_waitrequest, half_cycle_tick = 1'b0;
   logic [3:0] fast_in, exp_in, relay_coil;
   logic [3:0] setpoint_req = 4'h0;
   logic [3:0] energy_pulse = 4'h0;
   logic [7:0] shorted = 8'h00;
   logic [7:0] input_state;
   logic [1:0] lia, lib, lra, lrb;
   logic fault_trigger, demand_sync, clock_sync, tariff_change;
   logic [2:0] tariff_num;
   logic [72:0] rows [8];
   int miscompares = 0;
   int n_checks = 0;
   int cyc = 0;
   int dem_n = 0;
   int flt_n = 0;
   int tch_n = 0;
   int t0;

   mdiou_unit #(.MS_CYCLES(20)) mdiou_unit_inst (.clk(clk), .rstn(rstn),
      .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
      .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
      .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
      .fast_in(fast_in), .exp_in(exp_in), .half_cycle_tick(half_cycle_tick),
      .setpoint_req(setpoint_req), .energy_pulse(energy_pulse), .relay_coil(relay_coil),
      .module_input_lamp_a(lia), .module_input_lamp_b(lib), .module_relay_lamp_a(lra),
      .module_relay_lamp_b(lrb), .input_state(input_state), .fault_trigger(fault_trigger),
      .demand_sync(demand_sync), .clock_sync(clock_sync), .tariff_num(tariff_num),
      .tariff_change(tariff_change));
   mdiou_contacts mdiou_contacts_inst (.clk(clk), .shorted(shorted), .fast_in(fast_in),
      .exp_in(exp_in));

   // ----
   // Clock, ticks and tallies
   // ----
   initial begin
      forever #25 clk = ~clk;
   end
   // A half-cycle tick every ten clocks keeps relay tests short.
   always @(posedge clk) begin
      cyc <= cyc + 1;
      half_cycle_tick <= (cyc % 10 == 9);
      dem_n <= dem_n + int'(demand_sync === 1'b1);
      flt_n <= flt_n + int'(fault_trigger === 1'b1);
      tch_n <= tch_n + int'(tariff_change === 1'b1);
   end
   // Cuts a hang short well past the expected run length.
   initial begin
      repeat (20000) @(posedge clk);
      miscompares++;
      end_sim();
   end

   // ----
   // Tasks
   // ----
   task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      logic w;
      int n;
      n = 0;
      @(posedge clk);
      avs_address <= a;
      avs_writedata <= d;
      avs_write <= wr;
      avs_read <= !wr;
      do begin
         @(posedge clk);
         w = avs_waitrequest;
         q = avs_readdata;
         n++;
      end while (w !== 1'b0 && n < 100);
      if (n >= 100) miscompares++;
      avs_write <= 1'b0;
      avs_read <= 1'b0;
   endtask
   task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
      n_checks++;
      if (g !== e) begin
         miscompares++;
         $display("unexpected %s: expected %h, seen %h", nm, e, g);
      end
   endtask
   // Waits for n half-cycle ticks, then lets the relay update land.
   task automatic tk(input int n);
      repeat (n) @(posedge clk iff half_cycle_tick === 1'b1);
      @(negedge clk);
   endtask
   task automatic pulse0;
      @(posedge clk);
      energy_pulse <= 4'h1;
      @(posedge clk);
      energy_pulse <= 4'h0;
   endtask
   task automatic wait_in(input logic v);
      int n;
      n = 0;
      while (input_state[0] !== v && n < 400) begin
         @(negedge clk);
         n++;
      end
      if (n >= 400) miscompares++;
   endtask
   task automatic end_sim;
      $display("checks %0d, miscompares %0d", n_checks, miscompares);
      if (miscompares == 0 && n_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   // ----
   // Main sequence
   // ----
   initial begin
      rows[0] = {1'b0, 8'h00, 32'h0000_0000, 32'h0A0A_0A0A};
      rows[1] = {1'b0, 8'h04, 32'h0000_0000, 32'h0A0A_0A0A};
      rows[2] = {1'b0, 8'h1C, 32'h0000_0000, 32'h0000_0001};
      rows[3] = {1'b0, 8'h08, 32'h0000_0000, 32'h0000_0000};
      rows[4] = {1'b1, 8'h30, 32'hFFFF_FFFF, 32'h0000_0000};
      rows[5] = {1'b1, 8'h20, 32'hFFFF_FFFF, 32'h0000_0000};
      rows[6] = {1'b1, 8'h18, 32'h0000_0002, 32'h0000_0002};
      rows[7] = {1'b1, 8'h00, 32'h0A0A_0A03, 32'h0A0A_0A03};
      repeat (10) @(posedge clk);
      rstn <= 1'b1;
      chk("coil_rst", 32'h0000_0000, {28'h0, relay_coil});
      foreach (rows[i]) begin
         if (rows[i][72]) bus(1'b1, rows[i][71:64], rows[i][63:32]);
         bus(1'b0, rows[i][71:64], 32'h0000_0000);
         chk($sformatf("reg %h", rows[i][71:64]), rows[i][31:0], q);
      end
      // Input 0 feeds counter, billing, fault and demand sync at once.
      bus(1'b1, 8'h1C, 32'h0000_0005);
      bus(1'b1, 8'h08, 32'h0101_0101);
      bus(1'b1, 8'h0C, 32'h0000_1188);
      @(posedge clk);
      shorted <= 8'h11;
      t0 = cyc;
      wait_in(1'b1);
      chk("deb_time", 32'h1, {31'h0, (cyc - t0 >= 55) && (cyc - t0 <= 100)});
      repeat (3) @(negedge clk);
      chk("demand", 32'h1, dem_n);
      chk("fault", 32'h1, flt_n);
      chk("tariff", 32'h1, {29'h0, tariff_num});
      chk("tariff_chg", 32'h1, tch_n);
      chk("in_lamp", 32'h1, {28'h0, lib, lia});
      bus(1'b0, 8'h40, 32'h0000_0000);
      chk("count", 32'h1, q);
      bus(1'b0, 8'h60, 32'h0000_0000);
      chk("bill", 32'h5, q);
      // External fault triggering off: the other functions still count.
      bus(1'b1, 8'h08, 32'h0001_0101);
      @(posedge clk);
      shorted <= 8'h10;
      wait_in(1'b0);
      @(posedge clk);
      shorted <= 8'h11;
      wait_in(1'b1);
      repeat (3) @(negedge clk);
      chk("fault_off", 32'h1, flt_n);
      chk("demand2", 32'h2, dem_n);
      bus(1'b0, 8'h40, 32'h0000_0000);
      chk("count2", 32'h2, q);
      // Relay 0 pulses from the energy source, relay 1 latches remotely.
      bus(1'b1, 8'h10, 32'h0000_0812);
      tk(1);
      pulse0();
      tk(1);
      chk("pulse_on", 32'h1, {31'h0, relay_coil[0]});
      chk("out_lamp", 32'h1, {31'h0, lra[0]});
      tk(1);
      chk("pulse_hold", 32'h1, {31'h0, relay_coil[0]});
      tk(1);
      chk("pulse_off", 32'h0, {31'h0, relay_coil[0]});
      chk("absent", 32'h0, {31'h0, relay_coil[2]});
      bus(1'b1, 8'h14, 32'h0000_0002);
      tk(1);
      chk("latch_on", 32'h1, {31'h0, relay_coil[1]});
      bus(1'b1, 8'h14, 32'h0000_0000);
      tk(1);
      chk("latch_hold", 32'h1, {31'h0, relay_coil[1]});
      bus(1'b1, 8'h14, 32'h0000_0020);
      tk(1);
      chk("latch_rel", 32'h0, {31'h0, relay_coil[1]});
      // Relay 1 inverted from a setpoint; relay 0 toggles per pulse.
      bus(1'b1, 8'h10, 32'h0000_0513);
      tk(1);
      chk("inv_idle", 32'h1, {31'h0, relay_coil[1]});
      @(posedge clk);
      setpoint_req <= 4'h2;
      tk(1);
      chk("inv_oper", 32'h0, {31'h0, relay_coil[1]});
      pulse0();
      tk(1);
      chk("toggle1", 32'h1, {31'h0, relay_coil[0]});
      pulse0();
      tk(1);
      chk("toggle2", 32'h0, {31'h0, relay_coil[0]});
      end_sim();
   end
endmodule // meter_digital_io_unit_test

`default_nettype wire
